// >>> rtl/tmrb_pkg.sv
package tmrb_pkg;

   localparam int TMRB_W = 16;
   localparam int TMRB_CHANNELS = 6;
   localparam logic [TMRB_W-1:0] TMRB_CNT_RESET = 16'h0000;
   localparam logic [TMRB_W-1:0] TMRB_CNT_MAX = 16'hFFFF;
   localparam logic [TMRB_W-1:0] TMRB_CNT_ONE = 16'h0001;
   localparam logic [4:0] TMRB_DIV8_LAST = 5'h07;
   localparam logic [4:0] TMRB_DIV32_LAST = 5'h1F;
   localparam int TMRB_MODE_LSB = 0;
   localparam int TMRB_MODE_W = 2;

   typedef enum logic [1:0] {
      TMRB_MODE_TIMER = 2'h0,
      TMRB_MODE_EVENT = 2'h1,
      TMRB_MODE_MEASURE = 2'h2,
      TMRB_MODE_RSVD = 2'h3
   } tmrb_mode_t;

   typedef enum logic [1:0] {
      TMRB_SRC_DIV1 = 2'h0,
      TMRB_SRC_DIV8 = 2'h1,
      TMRB_SRC_DIV32 = 2'h2,
      TMRB_SRC_SUB32 = 2'h3
   } tmrb_src_t;

   typedef enum logic [1:0] {
      TMRB_EDGE_FALL = 2'h0,
      TMRB_EDGE_RISE = 2'h1,
      TMRB_EDGE_BOTH = 2'h2,
      TMRB_EDGE_RSVD = 2'h3
   } tmrb_edge_t;

   typedef enum logic [1:0] {
      TMRB_MEAS_PERIOD_FALL = 2'h0,
      TMRB_MEAS_PERIOD_RISE = 2'h1,
      TMRB_MEAS_WIDTH = 2'h2,
      TMRB_MEAS_RSVD = 2'h3
   } tmrb_meas_t;

   typedef struct packed {
      logic [5:0] rsvd;
      tmrb_src_t src;
      logic event_from_overflow;
      tmrb_edge_t edge_sel;
      tmrb_meas_t meas_sel;
      tmrb_mode_t mode;
   } tmrb_cfg_t;

   typedef struct packed {
      logic wr;
      logic [TMRB_W-1:0] data;
   } tmrb_wr_t;

endpackage : tmrb_pkg

// >>> rtl/tmrb_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tmrb_prescaler
   import tmrb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic subclk_tick,
   output logic sysclk_div8,
   output logic sysclk_div32,
   output logic subclk_div32
);

   logic [4:0] sys_cnt;
   logic [4:0] sub_cnt;
   wire logic sys_last8 = (sys_cnt[2:0] == TMRB_DIV8_LAST[2:0]);
   wire logic sys_last32 = (sys_cnt == TMRB_DIV32_LAST);
   wire logic sub_last32 = subclk_tick && (sub_cnt == TMRB_DIV32_LAST);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_cnt <= 5'h00;
         sub_cnt <= 5'h00;
         sysclk_div8 <= 1'b0;
         sysclk_div32 <= 1'b0;
         subclk_div32 <= 1'b0;
      end else begin
         sys_cnt <= sys_cnt + 5'h01;
         if (subclk_tick) begin
            sub_cnt <= sub_cnt + 5'h01;
         end
         sysclk_div8 <= sys_last8;
         sysclk_div32 <= sys_last32;
         subclk_div32 <= sub_last32;
      end
   end

endmodule : tmrb_prescaler
`default_nettype wire

// >>> rtl/tmrb_channel.sv
`timescale 1ns/100ps
`default_nettype none
module tmrb_channel
   import tmrb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic subclk_tick,
   input wire logic count_start,
   input wire logic mode_wr,
   input wire tmrb_cfg_t mode_cfg,
   input wire tmrb_wr_t timer_wr,
   input wire logic channel_event_input_pin,
   input wire logic measure_pulse_input_pin,
   input wire logic timer_overflow_in,
   output logic [TMRB_W-1:0] timer_rdata,
   output logic overflow_flag,
   output logic result_valid,
   output logic irq,
   output logic [TMRB_W-1:0] counter_value
);

   logic sysclk_div8;
   logic sysclk_div32;
   logic subclk_div32;
   tmrb_cfg_t cfg;
   logic [TMRB_W-1:0] counter;
   logic [TMRB_W-1:0] reload;
   logic evt_pin_q;
   logic meas_pin_q;
   logic [1:0] edge_count;
   logic ovf_count_seen;
   logic run_q;

   // Only one channel of the group is built here; it has a prescaler of its own.
   tmrb_prescaler u_prescaler (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .subclk_tick(subclk_tick),
      .sysclk_div8(sysclk_div8),
      .sysclk_div32(sysclk_div32),
      .subclk_div32(subclk_div32)
   );

   function automatic logic edge_hit(input logic prev, input logic now, input logic rise,
                                     input logic fall);
      edge_hit = (rise && !prev && now) || (fall && prev && !now);
   endfunction : edge_hit

   // The mode field is taken from the two lowest mode bits.
   wire tmrb_mode_t mode = tmrb_mode_t'(cfg[TMRB_MODE_LSB +: TMRB_MODE_W]);
   wire logic is_measure = (mode == TMRB_MODE_MEASURE);
   wire logic is_event = (mode == TMRB_MODE_EVENT);
   wire logic is_down = (mode == TMRB_MODE_TIMER) || is_event;

   wire logic int_tick = (cfg.src == TMRB_SRC_DIV1) ? 1'b1 :
                         (cfg.src == TMRB_SRC_DIV8) ? sysclk_div8 :
                         (cfg.src == TMRB_SRC_DIV32) ? sysclk_div32 : subclk_div32;

   wire logic evt_rise = (cfg.edge_sel == TMRB_EDGE_RISE) || (cfg.edge_sel == TMRB_EDGE_BOTH);
   wire logic evt_fall = (cfg.edge_sel == TMRB_EDGE_FALL) || (cfg.edge_sel == TMRB_EDGE_BOTH);
   wire logic pin_event = edge_hit(evt_pin_q, channel_event_input_pin, evt_rise, evt_fall);
   wire logic ext_tick = cfg.event_from_overflow ? timer_overflow_in : pin_event;

   // Period uses one edge polarity; width measures between every edge.
   wire logic meas_rise = (cfg.meas_sel == TMRB_MEAS_PERIOD_RISE) ||
                          (cfg.meas_sel == TMRB_MEAS_WIDTH);
   wire logic meas_fall = (cfg.meas_sel == TMRB_MEAS_PERIOD_FALL) ||
                          (cfg.meas_sel == TMRB_MEAS_WIDTH);
   wire logic meas_edge = count_start && is_measure &&
                          edge_hit(meas_pin_q, measure_pulse_input_pin, meas_rise, meas_fall);

   wire logic tick = count_start && (is_event ? ext_tick : int_tick);
   wire logic down_tick = tick && is_down;
   wire logic up_tick = tick && is_measure;
   wire logic underflow = down_tick && (counter == TMRB_CNT_RESET);
   wire logic meas_ovf = up_tick && !meas_edge && (counter == TMRB_CNT_MAX);
   // An edge in the very cycle that counting starts is the first edge of the new run.
   wire logic first_edge = (edge_count == 2'h0) || start_rise;
   wire logic start_rise = count_start && !run_q;

   // A timer write while stopped also lands in the counter; in measure mode it is dropped.
   wire logic wr_ok = timer_wr.wr && !is_measure;
   wire logic wr_counter = wr_ok && !count_start;

   logic [TMRB_W-1:0] next_counter;
   logic [TMRB_W-1:0] next_reload;
   logic [1:0] next_edge_count;
   logic next_overflow_flag;
   logic next_ovf_count_seen;
   logic next_irq;

   always_comb begin
      next_counter = counter;
      if (wr_counter) begin
         next_counter = timer_wr.data;
      end else if (underflow) begin
         next_counter = reload;
      end else if (down_tick) begin
         next_counter = counter - TMRB_CNT_ONE;
      end else if (meas_edge) begin
         next_counter = TMRB_CNT_RESET;
      end else if (up_tick) begin
         next_counter = counter + TMRB_CNT_ONE;
      end
   end

   always_comb begin
      next_reload = reload;
      if (wr_ok) begin
         next_reload = timer_wr.data;
      end else if (meas_edge) begin
         next_reload = counter;
      end
   end

   always_comb begin
      next_edge_count = edge_count;
      if (start_rise) begin
         next_edge_count = meas_edge ? 2'h1 : 2'h0;
      end else if (meas_edge && (edge_count != 2'h2)) begin
         next_edge_count = edge_count + 2'h1;
      end
   end

   // The flag clears only on a mode write made while counting runs, after at least one count since it was set.
   always_comb begin
      next_overflow_flag = overflow_flag;
      next_ovf_count_seen = ovf_count_seen;
      if (meas_ovf) begin
         next_overflow_flag = 1'b1;
         next_ovf_count_seen = 1'b0;
      end else begin
         if (overflow_flag && tick) begin
            next_ovf_count_seen = 1'b1;
         end
         if (mode_wr && count_start && overflow_flag && ovf_count_seen) begin
            next_overflow_flag = 1'b0;
         end
      end
   end

   always_comb begin
      next_irq = underflow;
      if (meas_edge && !first_edge) begin
         next_irq = 1'b1;
      end
      if (meas_ovf) begin
         next_irq = 1'b1;
      end
   end

   wire logic [TMRB_W-1:0] next_rdata = is_measure ? next_reload : next_counter;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= '0;
         evt_pin_q <= 1'b0;
         meas_pin_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         if (mode_wr) begin
            cfg <= mode_cfg;
         end
         evt_pin_q <= channel_event_input_pin;
         meas_pin_q <= measure_pulse_input_pin;
         run_q <= count_start;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         counter <= TMRB_CNT_RESET;
         reload <= TMRB_CNT_RESET;
         edge_count <= 2'h0;
         overflow_flag <= 1'b0;
         ovf_count_seen <= 1'b0;
      end else begin
         counter <= next_counter;
         reload <= next_reload;
         edge_count <= next_edge_count;
         overflow_flag <= next_overflow_flag;
         ovf_count_seen <= next_ovf_count_seen;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_rdata <= TMRB_CNT_RESET;
         counter_value <= TMRB_CNT_RESET;
         result_valid <= 1'b0;
         irq <= 1'b0;
      end else begin
         timer_rdata <= next_rdata;
         counter_value <= next_counter;
         result_valid <= !is_measure || (next_edge_count == 2'h2);
         irq <= next_irq;
      end
   end

endmodule : tmrb_channel
`default_nettype wire

// >>> dv/tmrb_channel_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module tmrb_channel_chk
   import tmrb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic count_start,
   input wire logic mode_wr,
   input wire tmrb_cfg_t mode_cfg,
   input wire tmrb_wr_t timer_wr,
   input wire logic overflow_flag,
   input wire logic irq,
   input wire logic [TMRB_W-1:0] counter_value
);
   tmrb_cfg_t cfg_q;
   logic wq;
   // A shadow of the mode register, so every check knows the mode in force.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= '0;
         wq <= 1'b0;
      end else begin
         wq <= mode_wr;
         if (mode_wr) begin
            cfg_q <= mode_cfg;
         end
      end
   end
   wire logic tmr1 = cfg_q.mode == TMRB_MODE_TIMER && cfg_q.src == TMRB_SRC_DIV1 && !mode_wr;
   wire logic meas = cfg_q.mode == TMRB_MODE_MEASURE && !mode_wr && !wq;
   wire logic run1 = count_start && !timer_wr.wr;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_hold; !count_start && !timer_wr.wr && !mode_wr |=> $stable(counter_value); endproperty
   a_hold: assert property (p_hold) else $error("stopped counter moved");
   property p_down; run1 && tmr1 && counter_value != 16'h0000
      |=> counter_value == $past(counter_value) - 16'h0001; endproperty
   a_down: assert property (p_down) else $error("no down count");
   property p_under; run1 && tmr1 && counter_value == 16'h0000 |=> irq; endproperty
   a_under: assert property (p_under) else $error("no irq on underflow");
   property p_load; !count_start && timer_wr.wr && !mode_wr && cfg_q.mode != TMRB_MODE_MEASURE
      |=> counter_value == $past(timer_wr.data); endproperty
   a_load: assert property (p_load) else $error("stopped write not loaded");
   property p_zero; meas && irq |-> counter_value == 16'h0000; endproperty
   a_zero: assert property (p_zero) else $error("no restart at capture");
   property p_up; run1 && meas && cfg_q.src == TMRB_SRC_DIV1
      |=> counter_value == $past(counter_value) + 16'h0001 || counter_value == 16'h0000; endproperty
   a_up: assert property (p_up) else $error("no up count");
   property p_flag; $rose(overflow_flag) |-> irq; endproperty
   a_flag: assert property (p_flag) else $error("flag without irq");
   property p_keep; overflow_flag && mode_wr && !count_start |=> overflow_flag; endproperty
   a_keep: assert property (p_keep) else $error("flag cleared while stopped");
endmodule : tmrb_channel_chk
bind tmrb_channel tmrb_channel_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
   .count_start(count_start), .mode_wr(mode_wr), .mode_cfg(mode_cfg), .timer_wr(timer_wr),
   .overflow_flag(overflow_flag), .irq(irq), .counter_value(counter_value));
`default_nettype wire

// >>> dv/tmrb_pulse_src.sv
`timescale 1ns/100ps
`default_nettype none
module tmrb_pulse_src #(
   parameter int HALF = 10
) (
   input wire logic sys_clk,
   input wire logic en,
   output logic pin
);
   int cnt;
   // A stopped source rests low, as if pulled down, so it makes no edges after the cycle that stops it.
   always @(posedge sys_clk) begin
      if (!en) begin
         cnt <= 0;
         pin <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         pin <= !pin;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : tmrb_pulse_src
`default_nettype wire

// >>> dv/tmrb_channel_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tmrb_channel_tb_top;
   import tmrb_pkg::*;
   logic sys_clk, rst_n, subclk_tick, count_start, mode_wr, ev_pin, ovf_in, src_en, m_pin;
   logic overflow_flag, result_valid, irq;
   logic [15:0] timer_rdata, counter_value;
   tmrb_cfg_t mode_cfg, c;
   tmrb_wr_t timer_wr;
   int fail_count, n_checks, n;
   tmrb_pulse_src #(.HALF(10)) src_u (.sys_clk(sys_clk), .en(src_en), .pin(m_pin));
   tmrb_channel dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .subclk_tick(subclk_tick),
      .count_start(count_start), .mode_wr(mode_wr), .mode_cfg(mode_cfg), .timer_wr(timer_wr),
      .channel_event_input_pin(ev_pin), .measure_pulse_input_pin(m_pin),
      .timer_overflow_in(ovf_in), .timer_rdata(timer_rdata), .overflow_flag(overflow_flag),
      .result_valid(result_valid), .irq(irq), .counter_value(counter_value));
   initial begin
      sys_clk = 0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      subclk_tick = 0;
      forever begin
         repeat (3) @(posedge sys_clk);
         subclk_tick <= 1;
         @(posedge sys_clk) subclk_tick <= 0;
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic wait_irq();
      n = 0;
      do begin
         tick(1);
         n++;
      end while (irq !== 1'b1 && n < 600);
      if (n >= 600) begin
         fail_count++;
         finish_test();
      end
   endtask : wait_irq
   task automatic set_cfg();
      @(posedge sys_clk) mode_cfg <= c;
      mode_wr <= 1;
      @(posedge sys_clk) mode_wr <= 0;
      #1;
   endtask : set_cfg
   task automatic wr(input logic [15:0] d);
      @(posedge sys_clk) timer_wr <= {1'b1, d};
      @(posedge sys_clk) timer_wr.wr <= 1'b0;
      #1;
   endtask : wr
   task automatic run(input logic on);
      @(posedge sys_clk) count_start <= on;
   endtask : run
   task automatic t_timer();
      logic [15:0] v;
      wr(16'h0003);
      check("stopped write", counter_value, 16'h0003);
      run(1);
      wr(16'h0005);
      check("running write", counter_value, 16'h0001);
      check("live read", timer_rdata, 16'h0001);
      wait_irq();
      check("next reload", counter_value, 16'h0005);
      run(0);
      tick(0);
      v = counter_value;
      tick(4);
      check("hold", counter_value, v);
   endtask : t_timer
   task automatic t_src();
      int per [4] = '{2, 16, 64, 256};
      for (int s = 0; s < 4; s++) begin
         c = '0;
         c.src = tmrb_src_t'(s);
         set_cfg();
         wr(16'h0001);
         run(1);
         wait_irq();
         wait_irq();
         check("irq period", 16'(n), 16'(per[s]));
         run(0);
      end
   endtask : t_src
   task automatic t_event();
      logic [15:0] left [4] = '{16'h0006, 16'h0006, 16'h0003, 16'h0003};
      for (int i = 0; i < 4; i++) begin
         c = '0;
         c.mode = TMRB_MODE_EVENT;
         c.edge_sel = tmrb_edge_t'(i % 3);
         c.event_from_overflow = (i == 3);
         set_cfg();
         wr(16'h0009);
         run(1);
         repeat (6) begin
            @(posedge sys_clk) ev_pin <= !ev_pin;
            ovf_in <= (i == 3);
            @(posedge sys_clk) ovf_in <= 0;
            tick(1);
         end
         run(0);
         tick(1);
         check("events", counter_value, left[i]);
      end
   endtask : t_event
   task automatic t_meas();
      c = '0;
      c.mode = TMRB_MODE_MEASURE;
      c.meas_sel = TMRB_MEAS_PERIOD_RISE;
      set_cfg();
      run(1);
      src_en <= 1;
      n = 0;
      repeat (20) begin
         tick(1);
         n += (irq === 1'b1);
      end
      check("first edge irq", 16'(n), 16'h0000);
      check("valid early", result_valid, 1'b0);
      wait_irq();
      check("period", timer_rdata, 16'h0013);
      check("valid", result_valid, 1'b1);
      wait_irq();
      check("irq each edge", 16'(n), 16'h0014);
      wr(16'h1234);
      check("write ignored", timer_rdata, 16'h0013);
      c.meas_sel = TMRB_MEAS_WIDTH;
      set_cfg();
      wait_irq();
      wait_irq();
      check("width", timer_rdata, 16'h0009);
      @(posedge sys_clk) src_en <= 0;
      tick(2);
      run(0);
   endtask : t_meas
   task automatic t_ovf();
      run(1);
      n = 0;
      while (overflow_flag !== 1'b1 && n < 70000) begin
         tick(1);
         n++;
      end
      if (n >= 70000) begin
         fail_count++;
         finish_test();
      end
      check("overflow irq", irq, 1'b1);
      run(0);
      set_cfg();
      check("flag kept", overflow_flag, 1'b1);
      run(1);
      tick(3);
      set_cfg();
      check("flag cleared", overflow_flag, 1'b0);
   endtask : t_ovf
   initial begin
      rst_n = 0;
      count_start = 0;
      mode_wr = 0;
      ev_pin = 0;
      ovf_in = 0;
      src_en = 0;
      mode_cfg = '0;
      timer_wr = '0;
      fail_count = 0;
      n_checks = 0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1;
      t_timer();
      t_src();
      t_event();
      t_meas();
      t_ovf();
      finish_test();
   end
endmodule : tmrb_channel_tb_top
`default_nettype wire
